// ===== src/mafc_top.sv
// Master axis format converter with virtual generator and APB registers.
// How it works
// R1 - Generator positions count in 0.0001 mm, inch or degree steps.
// R2 - Generator modulo accepts 0 to 214748.3647; other writes ignored.
// R3 - Absolute generator position saturates at the signed 32-bit range.
// R4 - Generator position and velocity load only while generator inactive.
// R5 - Every scaled source except generator modulo with revs zero becomes 2^bits increments per master revolution.
// R6 - One converter, one master output shared by both axes.
// R7 - Selection zero stops the converter; any other selection runs it.
// R8 - Any nonzero second selection while the first selection is nonzero raises the duplicate selection diagnostic.
// R9 - Modulo feedback: divide by drive modulo, times revs and 2^bits.
// R10 - Rotary absolute feedback or command: divide by 360 degrees.
// R11 - Linear absolute source: divide by slave feed travel.
// R12 - Measuring encoder is copied unchanged.
// R13 - Modulo command uses cycle modulo when sync mode active.
// R14 - Modulo cycle position: divide by cycle modulo, times revs.
// R15 - Generator modulo with revs nonzero: divide by generator modulo.
// R16 - Revs zero: generator ratio times 4294967295 minus 2147483648.
// R17 - Revs zero: one generator modulo turn is the full word, 4096 master revolutions at 20 bits.
// R18 - Absolute generator: divide by virtual feed travel.
// R19 - Global registers are copied unchanged.
// R20 - Global registers selectable only with control package installed.
// R21 - Cross-drive containers 1 to 7 are copied unchanged.
// R22 - Generator steps every 2 ms, linearly interpolated per loop tick.
// R23 - One new 32-bit signed result per position loop tick.
`timescale 1ns/1ns
`include "mafc_regs.svh"
module mafc_top
#(
  parameter int GEN_PERIOD_CYC = `MAFC_GEN_PERIOD_CYC,
  parameter int LOOP_SHIFT     = 3
)
(
  // Clock and reset.
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave.
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Position loop timing and sources.
  input  wire logic               loop_tick,
  input  wire logic [31:0]        fb1_pos,
  input  wire logic [31:0]        fb2_pos,
  input  wire logic [31:0]        fb_act_pos,
  input  wire logic [31:0]        meas_pos,
  input  wire logic [31:0]        cmd_pos,
  input  wire logic [31:0]        avc_pos,
  input  wire logic [7:0][31:0]   global_reg,
  input  wire logic [6:0][31:0]   cross_drive_communication,
  // Master axis output shared by both axes.
  output logic      [31:0]        master_pos,
  output logic                    master_valid,
  output logic                    duplicate_selection_diagnostic
);

  mafc_pkg::mafc_main_type s_q;
  mafc_pkg::mafc_main_type s_d;
  mafc_div_if              div ();

  mafc_divider u_div
  (
    .pclk    (pclk),
    .presetn (presetn),
    .div     (div)
  );

  // Steps a position by a delta, wrapping in modulo or saturating.
  function automatic logic [31:0] step_pos(input logic [31:0] pos,
                                          input logic [31:0] delta,
                                          input logic        modulo,
                                          input logic [31:0] md);
    logic [32:0] sum;
    sum = {pos[31], pos} + {delta[31], delta};
    if (modulo && md != 32'h0000_0000)
    begin
      if ($signed(sum) >= $signed({1'b0, md}))
        sum = sum - {1'b0, md};
      else if (sum[32])
        sum = sum + {1'b0, md};
      step_pos = sum[31:0];
    end
    else if (sum[32] != sum[31])
      step_pos = sum[32] ? 32'h8000_0000 : 32'h7FFF_FFFF; // see R3
    else
      step_pos = sum[31:0];
  endfunction : step_pos

  logic        apb_access;
  logic        apb_commit;
  logic        running;
  logic        gen_tick;
  logic        copy_src;
  logic        div_src;
  logic        pkg_ok;
  logic [31:0] copy_val;
  logic [31:0] num;
  logic [31:0] den;
  logic [31:0] mult;
  logic        shift_en;
  logic        special;
  logic [31:0] num_mag;
  logic [63:0] prod;
  logic [95:0] dividend;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [31:0] gen_delta;

  assign apb_access = psel && penable && !s_q.pready;
  assign apb_commit = psel && penable && s_q.pready;
  assign running    = s_q.sel != `MAFC_SRC_NONE; // see R7
  assign gen_tick   = s_q.gen_cnt == 20'(GEN_PERIOD_CYC - 1);
  assign pkg_ok     = s_q.ctrl[`MAFC_CTRL_PKG];
  assign gen_delta  = 32'($signed(s_q.gen_vel) >>> LOOP_SHIFT);

  // Source mux and scaling chosen per selection and scaling type.
  always_comb
  begin
    copy_src = 1'b0;
    div_src  = 1'b0;
    copy_val = 32'h0000_0000;
    num      = 32'h0000_0000;
    den      = 32'h0000_0001;
    mult     = 32'h0000_0001;
    shift_en = 1'b1;
    special  = 1'b0;
    if (s_q.sel == `MAFC_SRC_MEAS)
    begin
      copy_src = 1'b1;
      copy_val = meas_pos; // see R12
    end
    else if (s_q.sel[15:3] == `MAFC_SRC_GREG0 >> 3)
    begin
      copy_src = pkg_ok; // see R20
      copy_val = global_reg[s_q.sel[2:0]]; // see R19
    end
    else if (s_q.sel[15:4] == 12'h002 && s_q.sel[3:0] >= 4'h1 &&
             s_q.sel[3:0] <= 4'h7)
    begin
      copy_src = 1'b1;
      copy_val = cross_drive_communication[3'(s_q.sel[3:0] - 4'h1)]; // see R21
    end
    else if (s_q.sel == `MAFC_SRC_GEN)
    begin
      div_src = 1'b1;
      num = s_q.gen_fine;
      if (!s_q.ctrl[`MAFC_CTRL_GEN_MOD])
        den = s_q.vfeed; // see R18
      else if (s_q.rev_cycle != 32'h0000_0000)
      begin
        den  = s_q.gen_mod; // see R15
        mult = s_q.rev_cycle;
      end
      else
      begin
        // Full word per modulo turn, which is 4096 revolutions at 20 bits.
        den      = s_q.gen_mod; // see R17
        mult     = `MAFC_SPECIAL_MULT; // see R16
        shift_en = 1'b0;
        special  = 1'b1;
      end
    end
    else if (s_q.sel >= `MAFC_SRC_FB1 && s_q.sel <= `MAFC_SRC_AVC)
    begin
      div_src = 1'b1;
      case (s_q.sel)
        `MAFC_SRC_FB1: num = fb1_pos;
        `MAFC_SRC_FB2: num = fb2_pos;
        `MAFC_SRC_FB_ACT: num = fb_act_pos;
        `MAFC_SRC_CMD: num = cmd_pos;
        default: num = avc_pos;
      endcase
      if (s_q.ctrl[`MAFC_CTRL_DRV_MOD])
      begin
        mult = s_q.rev_cycle;
        if (s_q.sel == `MAFC_SRC_AVC)
          den = s_q.avc_mod; // see R14
        else if (s_q.sel == `MAFC_SRC_CMD && s_q.ctrl[`MAFC_CTRL_SYNC])
          den = s_q.avc_mod; // see R13
        else
          den = s_q.drv_mod; // see R9
      end
      else if (s_q.ctrl[`MAFC_CTRL_DRV_LIN])
        den = s_q.feed; // see R11
      else
        den = `MAFC_DEG_360; // see R10
    end
  end

  // Magnitude times multiplier, times 2^bits when shift_en is set, forms the dividend.
  assign num_mag  = num[31] ? -num : num;
  assign prod     = num_mag * mult;
  assign dividend = shift_en ? ({32'h0000_0000, prod} << s_q.bits)
                             : {32'h0000_0000, prod}; // see R5

  assign div.start    = s_q.st == mafc_pkg::ST_DIVIDE;
  assign div.dividend = dividend;
  assign div.divisor  = den;
  assign div.neg      = num[31];

  // Register read view.
  always_comb
  begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    if (paddr == `MAFC_OFF_CTRL)
      rd_word = {24'h00_0000, s_q.ctrl};
    else if (paddr == `MAFC_OFF_SEL)
      rd_word = {16'h0000, s_q.sel};
    else if (paddr == `MAFC_OFF_SEL2)
      rd_word = {16'h0000, s_q.sel2};
    else if (paddr == `MAFC_OFF_BITS)
      rd_word = {27'h000_0000, s_q.bits};
    else if (paddr == `MAFC_OFF_REV_CYCLE)
      rd_word = s_q.rev_cycle;
    else if (paddr == `MAFC_OFF_DRV_MOD)
      rd_word = s_q.drv_mod;
    else if (paddr == `MAFC_OFF_AVC_MOD)
      rd_word = s_q.avc_mod;
    else if (paddr == `MAFC_OFF_FEED)
      rd_word = s_q.feed;
    else if (paddr == `MAFC_OFF_VFEED)
      rd_word = s_q.vfeed;
    else if (paddr == `MAFC_OFF_GEN_MOD)
      rd_word = s_q.gen_mod;
    else if (paddr == `MAFC_OFF_GEN_POS)
      rd_word = s_q.gen_fine;
    else if (paddr == `MAFC_OFF_GEN_VEL)
      rd_word = s_q.gen_vel;
    else if (paddr == `MAFC_OFF_MASTER_POS)
      rd_word = s_q.master_pos;
    else if (paddr == `MAFC_OFF_STATUS)
      rd_word = {27'h000_0000, s_q.st != mafc_pkg::ST_IDLE, s_q.div_err,
                 s_q.bad_src, s_q.dup_diag, running};
    else
      rd_ok = 1'b0;
  end

  always_comb
  begin
    s_d = s_q;
    s_d.pready = apb_access;
    s_d.pslverr = 1'b0;
    s_d.master_valid = 1'b0;
    if (apb_access)
    begin
      s_d.prdata  = pwrite ? 32'h0000_0000 : rd_word;
      s_d.pslverr = !rd_ok;
    end
    if (apb_commit && pwrite)
    begin
      if (paddr == `MAFC_OFF_CTRL)
        s_d.ctrl = pwdata[7:0]; // see R1
      else if (paddr == `MAFC_OFF_SEL)
        s_d.sel = pwdata[15:0];
      else if (paddr == `MAFC_OFF_SEL2)
        s_d.sel2 = pwdata[15:0];
      else if (paddr == `MAFC_OFF_BITS)
        s_d.bits = pwdata[4:0];
      else if (paddr == `MAFC_OFF_REV_CYCLE)
        s_d.rev_cycle = pwdata;
      else if (paddr == `MAFC_OFF_DRV_MOD)
        s_d.drv_mod = pwdata;
      else if (paddr == `MAFC_OFF_AVC_MOD)
        s_d.avc_mod = pwdata;
      else if (paddr == `MAFC_OFF_FEED)
        s_d.feed = pwdata;
      else if (paddr == `MAFC_OFF_VFEED)
        s_d.vfeed = pwdata;
      else if (paddr == `MAFC_OFF_GEN_MOD && pwdata <= `MAFC_GEN_MOD_MAX)
        s_d.gen_mod = pwdata; // see R2
      else if (paddr == `MAFC_OFF_GEN_POS && !s_q.ctrl[`MAFC_CTRL_GEN_ACT])
      begin
        s_d.gen_pos  = pwdata; // see R4
        s_d.gen_fine = pwdata;
      end
      else if (paddr == `MAFC_OFF_GEN_VEL && !s_q.ctrl[`MAFC_CTRL_GEN_ACT])
        s_d.gen_vel = pwdata; // see R4
    end
    // Generator: coarse step every period, fine step per loop tick.
    if (s_q.ctrl[`MAFC_CTRL_GEN_ACT])
    begin
      s_d.gen_cnt = gen_tick ? 20'h0_0000 : s_q.gen_cnt + 20'h0_0001;
      if (gen_tick)
      begin
        s_d.gen_pos  = step_pos(s_q.gen_pos, s_q.gen_vel,
                                s_q.ctrl[`MAFC_CTRL_GEN_MOD], s_q.gen_mod);
        s_d.gen_fine = s_d.gen_pos; // see R22
      end
      else if (loop_tick)
        s_d.gen_fine = step_pos(s_q.gen_fine, gen_delta,
                                s_q.ctrl[`MAFC_CTRL_GEN_MOD], s_q.gen_mod);
    end
    else
      s_d.gen_cnt = 20'h0_0000;
    s_d.dup_diag = running && s_q.sel2 != `MAFC_SRC_NONE; // see R8
    // One converter feeds the single shared master output.
    case (s_q.st)
      mafc_pkg::ST_IDLE:
      begin
        if (loop_tick && running) // see R7
        begin
          s_d.bad_src = !copy_src && !div_src;
          if (copy_src)
          begin
            s_d.master_pos   = copy_val; // see R6
            s_d.master_valid = 1'b1;
          end
          else if (div_src && den == 32'h0000_0000)
            s_d.div_err = 1'b1;
          else if (div_src)
          begin
            s_d.div_err = 1'b0;
            s_d.special = special;
            s_d.st      = mafc_pkg::ST_DIVIDE;
          end
        end
      end
      mafc_pkg::ST_DIVIDE:
        s_d.st = mafc_pkg::ST_FINISH;
      mafc_pkg::ST_FINISH:
      begin
        if (div.done && running) // see R7
        begin
          s_d.master_pos = s_q.special
                         ? div.quotient - `MAFC_SPECIAL_OFFSET // see R16
                         : div.quotient; // see R23
          s_d.master_valid = 1'b1;
        end
        if (div.done)
          s_d.st = mafc_pkg::ST_IDLE;
      end
      default:
        s_d.st = mafc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.st <= mafc_pkg::ST_IDLE;
    end
    else
      s_q <= s_d;
  end

  assign prdata                         = s_q.prdata;
  assign pready                         = s_q.pready;
  assign pslverr                        = s_q.pslverr;
  assign master_pos                     = s_q.master_pos;
  assign master_valid                   = s_q.master_valid;
  assign duplicate_selection_diagnostic = s_q.dup_diag;

  sequence seq_copy_tick;
    s_q.st == mafc_pkg::ST_IDLE && loop_tick && running;
  endsequence

  sequence seq_preload_write;
    apb_commit && pwrite && paddr == `MAFC_OFF_GEN_POS &&
    !s_q.ctrl[`MAFC_CTRL_GEN_ACT];
  endsequence

  a_null_stops: assert property (@(posedge pclk) disable iff (!presetn) // see R7
    !running && $stable(s_q.sel) |=> !master_valid)
    else $error("converter produced output with null selection");

  a_meas_copy: assert property (@(posedge pclk) disable iff (!presetn) // see R12
    seq_copy_tick and s_q.sel == `MAFC_SRC_MEAS
    |=> master_valid && master_pos == $past(meas_pos))
    else $error("measuring encoder not copied");

  a_greg_copy: assert property (@(posedge pclk) disable iff (!presetn) // see R19
    seq_copy_tick and s_q.sel[15:3] == 13'h0002 && pkg_ok
    |=> master_pos == $past(global_reg[s_q.sel[2:0]]))
    else $error("global register not copied");

  a_greg_no_pkg: assert property (@(posedge pclk) disable iff (!presetn) // see R20
    seq_copy_tick and s_q.sel[15:3] == 13'h0002 && !pkg_ok
    |=> !master_valid && s_q.bad_src)
    else $error("global register used without control package");

  a_dup_flag: assert property (@(posedge pclk) disable iff (!presetn) // see R8
    running && s_q.sel2 != `MAFC_SRC_NONE |=> duplicate_selection_diagnostic)
    else $error("duplicate selection not reported");

  a_gen_preload: assert property (@(posedge pclk) disable iff (!presetn) // see R4
    seq_preload_write |=> s_q.gen_pos == $past(pwdata))
    else $error("generator preload not taken");

  a_gen_mod_range: assert property (@(posedge pclk) disable iff (!presetn) // see R2
    !s_q.gen_mod[31])
    else $error("generator modulo out of range");

  a_gen_period: assert property (@(posedge pclk) disable iff (!presetn) // see R22
    s_q.gen_cnt <= 20'(GEN_PERIOD_CYC - 1))
    else $error("generator period counter overran");

  a_div_result: assert property (@(posedge pclk) disable iff (!presetn) // see R23
    s_q.st == mafc_pkg::ST_DIVIDE |-> ##[1:100] master_valid)
    else $error("scaled result not delivered in time");

  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    apb_access |=> pready ##1 !pready)
    else $error("APB ready not one-cycle after access");

endmodule : mafc_top

// ===== src/mafc_regs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef MAFC_REGS_SVH
`define MAFC_REGS_SVH

`define MAFC_OFF_CTRL        8'h00
`define MAFC_OFF_SEL         8'h04
`define MAFC_OFF_SEL2        8'h08
`define MAFC_OFF_BITS        8'h0C
`define MAFC_OFF_REV_CYCLE   8'h10
`define MAFC_OFF_DRV_MOD     8'h14
`define MAFC_OFF_AVC_MOD     8'h18
`define MAFC_OFF_FEED        8'h1C
`define MAFC_OFF_VFEED       8'h20
`define MAFC_OFF_GEN_MOD     8'h24
`define MAFC_OFF_GEN_POS     8'h28
`define MAFC_OFF_GEN_VEL     8'h2C
`define MAFC_OFF_MASTER_POS  8'h30
`define MAFC_OFF_STATUS      8'h34

`define MAFC_CTRL_GEN_ACT    0
`define MAFC_CTRL_DRV_MOD    1
`define MAFC_CTRL_DRV_LIN    2
`define MAFC_CTRL_GEN_MOD    3
`define MAFC_CTRL_GEN_UNIT   5:4
`define MAFC_CTRL_SYNC       6
`define MAFC_CTRL_PKG        7

`define MAFC_RST_WORD        32'h0000_0000
`define MAFC_RST_BITS        5'h00

`define MAFC_SRC_NONE        16'h0000
`define MAFC_SRC_FB1         16'h0001
`define MAFC_SRC_FB2         16'h0002
`define MAFC_SRC_FB_ACT      16'h0003
`define MAFC_SRC_MEAS        16'h0004
`define MAFC_SRC_CMD         16'h0005
`define MAFC_SRC_AVC         16'h0006
`define MAFC_SRC_GEN         16'h0007
`define MAFC_SRC_GREG0       16'h0010
`define MAFC_SRC_CCD1        16'h0021

`define MAFC_DEG_360         32'h0036_EE80
`define MAFC_GEN_MOD_MAX     32'h7FFF_FFFF
`define MAFC_SPECIAL_MULT    32'hFFFF_FFFF
`define MAFC_SPECIAL_OFFSET  32'h8000_0000

`define MAFC_CLK_MHZ         250
`define MAFC_GEN_PERIOD_MS   2
`define MAFC_GEN_PERIOD_CYC  (`MAFC_GEN_PERIOD_MS * 1000 * `MAFC_CLK_MHZ)

`endif

// ===== src/mafc_pkg.sv
// Types shared by the format converter and its divider.
package mafc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DIVIDE,
    ST_FINISH
  } mafc_state_type;

  typedef struct packed {
    logic [7:0]     ctrl;
    logic [15:0]    sel;
    logic [15:0]    sel2;
    logic [4:0]     bits;
    logic [31:0]    rev_cycle;
    logic [31:0]    drv_mod;
    logic [31:0]    avc_mod;
    logic [31:0]    feed;
    logic [31:0]    vfeed;
    logic [31:0]    gen_mod;
    logic [31:0]    gen_pos;
    logic [31:0]    gen_vel;
    logic [31:0]    gen_fine;
    logic [19:0]    gen_cnt;
    logic           special;
    logic [31:0]    master_pos;
    logic           master_valid;
    logic           dup_diag;
    logic           bad_src;
    logic           div_err;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    mafc_state_type st;
  } mafc_main_type;

  typedef struct packed {
    logic [95:0] quo;
    logic [32:0] rem;
    logic [31:0] divisor;
    logic [6:0]  cnt;
    logic        neg;
    logic        busy;
    logic        done;
    logic [31:0] result;
  } mafc_div_type;

endpackage : mafc_pkg

// ===== src/mafc_div_if.sv
// Request and answer signals between the converter and its divider.
`timescale 1ns/1ns
interface mafc_div_if;
  logic        start;
  logic [95:0] dividend;
  logic [31:0] divisor;
  logic        neg;
  logic        done;
  logic [31:0] quotient;

  modport req  (output start, dividend, divisor, neg, input done, quotient);
  modport calc (input start, dividend, divisor, neg, output done, quotient);
endinterface : mafc_div_if

// ===== src/mafc_divider.sv
// Sequential restoring divider: magnitude quotient, sign applied at the end.
`timescale 1ns/1ns
module mafc_divider
(
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Division port.
  mafc_div_if.calc  div
);

  mafc_pkg::mafc_div_type s_q;
  mafc_pkg::mafc_div_type s_d;
  logic [32:0]            rem_sh;

  always_comb
  begin
    s_d = s_q;
    rem_sh = {s_q.rem[31:0], s_q.quo[95]};
    s_d.done = 1'b0;
    if (div.start && !s_q.busy)
    begin
      s_d.quo = div.dividend;
      s_d.rem = 33'h0_0000_0000;
      s_d.divisor = div.divisor;
      s_d.neg = div.neg;
      s_d.cnt = 7'h60;
      s_d.busy = 1'b1;
    end
    else if (s_q.busy)
    begin
      s_d.quo = {s_q.quo[94:0], 1'b0};
      s_d.rem = rem_sh;
      if (rem_sh >= {1'b0, s_q.divisor})
      begin
        s_d.rem = rem_sh - {1'b0, s_q.divisor};
        s_d.quo[0] = 1'b1;
      end
      s_d.cnt = s_q.cnt - 7'h01;
      if (s_q.cnt == 7'h01)
      begin
        // The result keeps the low 32 bits, as a signed word.
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.result = s_q.neg ? -s_d.quo[31:0] : s_d.quo[31:0]; // see R23
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign div.done     = s_q.done;
  assign div.quotient = s_q.result;

  sequence seq_div_start;
    div.start && !s_q.busy;
  endsequence

  a_div_finish_bound: assert property (@(posedge pclk) disable iff (!presetn) // see R23
    seq_div_start |-> ##97 s_q.done)
    else $error("divider did not finish in 97 cycles");

endmodule : mafc_divider

// ===== tb/mafc_loop_model.sv
// Drive-side model: position loop tick and constant position sources.
`timescale 1ns/1ns
module mafc_loop_model
#(
  parameter int TICK_CYC = 128
)
(
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Loop timing and sources.
  output logic                  loop_tick,
  output logic [31:0]           fb1_pos,
  output logic [31:0]           fb2_pos,
  output logic [31:0]           fb_act_pos,
  output logic [31:0]           meas_pos,
  output logic [31:0]           cmd_pos,
  output logic [31:0]           avc_pos,
  output logic [7:0][31:0]      global_reg,
  output logic [6:0][31:0]      cross_drive_communication
);
  int cnt_q;

  // Ticks stay far enough apart for a divided conversion to finish.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= 0;
      loop_tick <= 1'b0;
    end
    else
    begin
      cnt_q <= (cnt_q == TICK_CYC - 1) ? 0 : cnt_q + 1;
      loop_tick <= (cnt_q == TICK_CYC - 1);
    end
  end

  assign fb1_pos    = 32'h001B_7740;
  assign fb2_pos    = 32'hFFF2_4460;
  assign fb_act_pos = 32'h000D_BBA0;
  assign meas_pos   = 32'h1234_5678;
  assign cmd_pos    = 32'h0000_00FA;
  assign avc_pos    = 32'h0000_01F4;

  for (genvar i = 0; i < 8; i++)
  begin : g_reg
    assign global_reg[i] = 32'h1000_0000 + 32'(i);
  end
  for (genvar i = 0; i < 7; i++)
  begin : g_cdc
    assign cross_drive_communication[i] = 32'h2000_0000 + 32'(i);
  end
endmodule : mafc_loop_model

// ===== tb/mafc_top_test.sv
// Self-checking testbench for the master axis format converter.
`timescale 1ns/1ns
`include "mafc_regs.svh"
module mafc_top_test;
  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [7:0]          paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                loop_tick;
  logic [31:0]         fb1_pos;
  logic [31:0]         fb2_pos;
  logic [31:0]         fb_act_pos;
  logic [31:0]         meas_pos;
  logic [31:0]         cmd_pos;
  logic [31:0]         avc_pos;
  logic [7:0][31:0]    global_reg;
  logic [6:0][31:0]    cross_drive_communication;
  logic [31:0]         master_pos;
  logic                master_valid;
  logic                duplicate_selection_diagnostic;
  int                  n_fail;
  int                  comparisons;
  int                  cycles;
  logic [31:0]         q;
  logic                e;
  bit                  v;

  mafc_top #(.GEN_PERIOD_CYC(64), .LOOP_SHIFT(3)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .loop_tick(loop_tick),
    .fb1_pos(fb1_pos), .fb2_pos(fb2_pos), .fb_act_pos(fb_act_pos),
    .meas_pos(meas_pos), .cmd_pos(cmd_pos), .avc_pos(avc_pos),
    .global_reg(global_reg),
    .cross_drive_communication(cross_drive_communication),
    .master_pos(master_pos), .master_valid(master_valid),
    .duplicate_selection_diagnostic(duplicate_selection_diagnostic));

  mafc_loop_model #(.TICK_CYC(128)) model (
    .pclk(pclk), .presetn(presetn), .loop_tick(loop_tick),
    .fb1_pos(fb1_pos), .fb2_pos(fb2_pos), .fb_act_pos(fb_act_pos),
    .meas_pos(meas_pos), .cmd_pos(cmd_pos), .avc_pos(avc_pos),
    .global_reg(global_reg),
    .cross_drive_communication(cross_drive_communication));

  task conclude;
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    cmp(q, exp);
  endtask : rd

  // Waits a bounded time for one master_valid pulse.
  task wait_valid;
    v = 1'b0;
    for (int i = 0; i < 300 && !v; i++)
    begin
      @(posedge pclk);
      v = (master_valid === 1'b1);
    end
  endtask : wait_valid

  // The first result may still come from the old setting; check the second.
  task conv(input logic [7:0] c, input logic [15:0] s, input logic [4:0] b,
            input logic [31:0] r, input logic [7:0] mo,
            input logic [31:0] m, input logic [31:0] exp);
    wr(`MAFC_OFF_BITS, {27'h0, b});
    wr(`MAFC_OFF_REV_CYCLE, r);
    wr(mo, m);
    wr(`MAFC_OFF_CTRL, {24'h00_0000, c});
    wr(`MAFC_OFF_SEL, {16'h0000, s});
    wait_valid();
    wait_valid();
    cmp({31'h0, v}, 32'h0000_0001);
    cmp(master_pos, exp);
  endtask : conv

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_fail++;
      conclude();
    end
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(`MAFC_OFF_CTRL, 32'h0000_0000);
    rd(`MAFC_OFF_SEL, 32'h0000_0000);
    rd(`MAFC_OFF_MASTER_POS, 32'h0000_0000);
    rd(8'h3C, 32'h0000_0000);
    cmp({31'h0, e}, 32'h0000_0001);
    wr(`MAFC_OFF_GEN_MOD, 32'h7FFF_FFFF);
    wr(`MAFC_OFF_GEN_MOD, 32'h8000_0000);
    rd(`MAFC_OFF_GEN_MOD, 32'h7FFF_FFFF);
    wr(`MAFC_OFF_GEN_VEL, 32'h0000_0000);
    wr(`MAFC_OFF_GEN_POS, 32'h0000_1388);
    wr(`MAFC_OFF_CTRL, 32'h0000_0001);
    wr(`MAFC_OFF_GEN_POS, 32'h0000_0999);
    rd(`MAFC_OFF_GEN_POS, 32'h0000_1388);
    conv(8'h00, 16'h0004, 5'h0C, 0, `MAFC_OFF_FEED, 0, 32'h1234_5678);
    conv(8'h00, 16'h0001, 5'h0C, 0, `MAFC_OFF_FEED, 1, 32'h0000_0800);
    conv(8'h00, 16'h0002, 5'h0C, 0, `MAFC_OFF_FEED, 1, 32'hFFFF_FC00);
    conv(8'h04, 16'h0005, 5'h04, 0, `MAFC_OFF_FEED, 100, 32'h0000_0028);
    conv(8'h02, 16'h0003, 5'h0A, 2, `MAFC_OFF_DRV_MOD, `MAFC_DEG_360,
         32'h0000_0200);
    conv(8'h42, 16'h0005, 5'h08, 1, `MAFC_OFF_AVC_MOD, 1000, 32'h0000_0040);
    conv(8'h02, 16'h0006, 5'h08, 1, `MAFC_OFF_AVC_MOD, 1000, 32'h0000_0080);
    conv(8'h00, 16'h0007, 5'h08, 0, `MAFC_OFF_VFEED, 10000, 32'h0000_0080);
    conv(8'h08, 16'h0007, 5'h08, 1, `MAFC_OFF_GEN_MOD, 10000,
         32'h0000_0080);
    conv(8'h08, 16'h0007, 5'h08, 0, `MAFC_OFF_GEN_MOD, 10000,
         32'hFFFF_FFFF);
    conv(8'h80, 16'h0013, 5'h08, 0, `MAFC_OFF_FEED, 1, 32'h1000_0003);
    for (int k = 0; k < 7; k++)
      conv(8'h00, 16'h0021 + 16'(k), 5'h08, 0, `MAFC_OFF_FEED, 1,
           32'h2000_0000 + 32'(k));
    wr(`MAFC_OFF_CTRL, 32'h0000_0000);
    wr(`MAFC_OFF_SEL, 32'h0000_0013);
    wait_valid();
    wait_valid();
    cmp({31'h0, v}, 32'h0000_0000);
    rd(`MAFC_OFF_STATUS, 32'h0000_0005);
    wr(`MAFC_OFF_SEL, 32'h0000_0004);
    wait_valid();
    cmp({31'h0, v}, 32'h0000_0001);
    wr(`MAFC_OFF_SEL2, 32'h0000_0005);
    repeat (2) @(posedge pclk);
    cmp({31'h0, duplicate_selection_diagnostic}, 32'h0000_0001);
    wr(`MAFC_OFF_SEL2, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    cmp({31'h0, duplicate_selection_diagnostic}, 32'h0000_0000);
    wr(`MAFC_OFF_SEL, 32'h0000_0000);
    wait_valid();
    wait_valid();
    cmp({31'h0, v}, 32'h0000_0000);
    rd(`MAFC_OFF_STATUS, 32'h0000_0000);
    conclude();
  end
endmodule : mafc_top_test
